// >>> include/fcw_regs.svh
// Summary of operation
// - Sample mode: sample-mode bit set and filter sample count equal to one.
// - Sample event is the rising edge of the selected window/sample signal.
// - Result captured at each sample event, held on output until the next.
// - Window mode: window-mode bit set and filter sample count equal to zero.
// - By default the window is open while the source signal is high.
// - While the window is open the comparison result passes to the output.
// - Window-polarity invert bit opens the window while the source is low.
// - The window/sample input is optionally inverted before use.
// - Output-invert bit inverts the comparator result before the output.
// - Window closing enabled: selected output edge (rise, fall, both) closes window early.
// - Software sets the output level shown while the window is closed.
// - A comparison already true at window opening is reported at the opening.
// - Both input muxes share indices: 2 unconnected, 6 reserved, 7 internal DAC.
// - Eight-bit DAC code selects one of 256 levels, full reference down to 1/256.
// - A select bit picks which of two reference sources feeds the DAC.
// - The compare event goes to other peripherals in hardware, e.g. PWM stop.
`ifndef FCW_REGS_SVH
`define FCW_REGS_SVH

// Filter sample count values that select the special modes
`define FCW_CNT_SAMPLE 3'h1
`define FCW_CNT_WINDOW 3'h0

// Close edge select field bit positions
`define FCW_EDGE_RISE_BIT 0
`define FCW_EDGE_FALL_BIT 1

// Input mux indices with special meaning
`define FCW_MUX_UNCONNECTED 3'h2
`define FCW_MUX_RESERVED 3'h6
`define FCW_MUX_INT_DAC 3'h7

// Reset values
`define FCW_RST_MUX_SEL 3'h0
`define FCW_RST_DAC_CODE 8'h00
`define FCW_RST_OUT 1'b0
`define FCW_RST_FILTER_SAMPLE_COUNT 3'h0
`define FCW_RST_DIV 8'h00

`endif

// >>> include/fcw_pkg.sv
package fcw_pkg;

  // Mode and output-conditioning controls
  typedef struct packed {
    logic sample_mode;
    logic window_mode;
    logic window_polarity_invert;
    logic output_invert;
    logic window_close_enable;
    logic [1:0] close_edge_select;
    logic closed_level;
    logic [2:0] filter_sample_count;
    logic [7:0] filter_period;
  } fcw_ctrl_s;

  // Analog front-end settings from software
  typedef struct packed {
    logic [2:0] plus_input_select;
    logic [2:0] minus_input_select;
    logic [7:0] dac_code;
    logic ref_select;
  } fcw_ana_cfg_s;

  // Analog front-end controls driven to the macro
  typedef struct packed {
    logic [2:0] plus_sel;
    logic [2:0] minus_sel;
    logic plus_connected;
    logic minus_connected;
    logic plus_from_dac;
    logic minus_from_dac;
    logic dac_enable;
    logic [7:0] dac_code;
    logic [8:0] dac_level;
    logic ref_select;
  } fcw_ana_out_s;

  typedef enum logic [2:0] {
    FCW_WIN_IDLE = 3'b001,
    FCW_WIN_OPEN = 3'b010,
    FCW_WIN_CLOSED = 3'b100
  } fcw_win_e;

  typedef enum logic [2:0] {
    FCW_MODE_CONT = 3'b001,
    FCW_MODE_SAMPLE = 3'b010,
    FCW_MODE_WINDOW = 3'b100
  } fcw_mode_e;

endpackage

// >>> design/fcw_edge_det.sv
`timescale 1ns/1ps
`default_nettype none

module fcw_edge_det
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Level in
  input wire logic level,
  // Edge pulses, valid in the cycle the new level is seen, and the registered previous level
  output logic rise,
  output logic fall,
  output logic prev
);

  logic prev_q;
  logic prev_d;

  always_comb
  begin
    prev_d = level;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      // Loaded with the level, so a source already high at release is not an edge
      prev_q <= level;
    end
    else
    begin
      prev_q <= prev_d;
    end
  end

  assign rise = level & ~prev_q;
  assign fall = ~level & prev_q;
  assign prev = prev_q;

endmodule // fcw_edge_det

`default_nettype wire

// >>> design/fcw_top.sv
`timescale 1ns/1ps
`default_nettype none

`include "fcw_regs.svh"

module fcw_top
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Software controls
  input wire fcw_pkg::fcw_ctrl_s ctrl,
  input wire fcw_pkg::fcw_ana_cfg_s ana_cfg,
  // Raw comparator decision from the analog core
  input wire logic cmp_raw,
  // Window or sample source from the trigger input mux
  input wire logic window_sample_in,
  // Conditioned output and event to other peripherals
  output logic comparator_result,
  output logic compare_event,
  // Analog front-end controls
  output fcw_pkg::fcw_ana_out_s ana_out,
  // Status
  output logic window_is_open,
  output fcw_pkg::fcw_mode_e mode_active
);

  // Mux index decode shared by both inputs
  function automatic logic fcw_mux_connected(input logic [2:0] idx);
    fcw_mux_connected = (idx != `FCW_MUX_UNCONNECTED) && (idx != `FCW_MUX_RESERVED);
  endfunction

  function automatic logic fcw_mux_dac(input logic [2:0] idx);
    fcw_mux_dac = (idx == `FCW_MUX_INT_DAC);
  endfunction

  function automatic logic fcw_edge_hit(input logic [1:0] sel, input logic r, input logic f);
    fcw_edge_hit = (sel[`FCW_EDGE_RISE_BIT] & r) | (sel[`FCW_EDGE_FALL_BIT] & f);
  endfunction

  // Mode decode
  fcw_pkg::fcw_mode_e mode;

  always_comb
  begin
    if (ctrl.sample_mode && (ctrl.filter_sample_count == `FCW_CNT_SAMPLE))
    begin
      mode = fcw_pkg::FCW_MODE_SAMPLE;
    end
    else if (ctrl.window_mode && (ctrl.filter_sample_count == `FCW_CNT_WINDOW))
    begin
      mode = fcw_pkg::FCW_MODE_WINDOW;
    end
    else
    begin
      mode = fcw_pkg::FCW_MODE_CONT;
    end
  end

  // Conditioned inputs
  logic ws;
  logic res;

  // The trigger mux routing itself is outside; only its output arrives here
  assign ws = window_sample_in ^ ctrl.window_polarity_invert;
  assign res = cmp_raw ^ ctrl.output_invert;

  logic ws_rise;
  logic ws_fall;
  logic res_rise;
  logic res_fall;

  fcw_edge_det u_ws_edge
  (
    .mclk(mclk),
    .rst_n(rst_n),
    .level(ws),
    .rise(ws_rise),
    .fall(ws_fall),
    .prev()
  );

  fcw_edge_det u_res_edge
  (
    .mclk(mclk),
    .rst_n(rst_n),
    .level(res),
    .rise(res_rise),
    .fall(res_fall),
    .prev()
  );

  // Filter clock enable divider
  logic [7:0] div_q;
  logic [7:0] div_d;
  logic div_tick;

  always_comb
  begin
    div_tick = (div_q >= ctrl.filter_period);
    if (div_tick)
    begin
      div_d = `FCW_RST_DIV;
    end
    else
    begin
      div_d = div_q + 8'h01;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      div_q <= `FCW_RST_DIV;
    end
    else
    begin
      div_q <= div_d;
    end
  end

  // Continuous-mode filter: a new level must be seen on N consecutive ticks
  logic filt_q;
  logic filt_d;
  logic [2:0] agree_q;
  logic [2:0] agree_d;
  logic filt_bypass;

  always_comb
  begin
    filt_bypass = (ctrl.filter_sample_count <= 3'h1);
    filt_d = filt_q;
    agree_d = agree_q;
    if (filt_bypass)
    begin
      filt_d = res;
      agree_d = `FCW_RST_FILTER_SAMPLE_COUNT;
    end
    else if (div_tick)
    begin
      if (res == filt_q)
      begin
        agree_d = `FCW_RST_FILTER_SAMPLE_COUNT;
      end
      else if ((agree_q + 3'h1) >= ctrl.filter_sample_count)
      begin
        filt_d = res;
        agree_d = `FCW_RST_FILTER_SAMPLE_COUNT;
      end
      else
      begin
        agree_d = agree_q + 3'h1;
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      filt_q <= `FCW_RST_OUT;
      agree_q <= `FCW_RST_FILTER_SAMPLE_COUNT;
    end
    else
    begin
      filt_q <= filt_d;
      agree_q <= agree_d;
    end
  end

  // Window state
  fcw_pkg::fcw_win_e win_q;
  fcw_pkg::fcw_win_e win_d;
  logic close_hit;

  always_comb
  begin
    close_hit = ctrl.window_close_enable
      && fcw_edge_hit(ctrl.close_edge_select, res_rise, res_fall);
    win_d = win_q;
    if (mode != fcw_pkg::FCW_MODE_WINDOW)
    begin
      win_d = fcw_pkg::FCW_WIN_IDLE;
    end
    else
    begin
      unique case (win_q)
        fcw_pkg::FCW_WIN_IDLE:
        begin
          if (ws)
          begin
            win_d = fcw_pkg::FCW_WIN_OPEN;
          end
        end
        fcw_pkg::FCW_WIN_OPEN:
        begin
          if (!ws)
          begin
            win_d = fcw_pkg::FCW_WIN_IDLE;
          end
          else if (close_hit)
          begin
            win_d = fcw_pkg::FCW_WIN_CLOSED;
          end
        end
        fcw_pkg::FCW_WIN_CLOSED:
        begin
          // Stays shut for the rest of this window, even if the output toggles back
          if (!ws)
          begin
            win_d = fcw_pkg::FCW_WIN_IDLE;
          end
        end
        default:
        begin
          win_d = fcw_pkg::FCW_WIN_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      win_q <= fcw_pkg::FCW_WIN_IDLE;
    end
    else
    begin
      win_q <= win_d;
    end
  end

  // Output select
  logic out_q;
  logic out_d;
  logic event_q;
  logic event_d;
  logic win_open_now;

  always_comb
  begin
    // Opening is taken from the level so a compare already true shows at once
    win_open_now = ((win_q == fcw_pkg::FCW_WIN_IDLE) && ws)
      || ((win_q == fcw_pkg::FCW_WIN_OPEN) && ws);
    out_d = out_q;
    unique case (mode)
      fcw_pkg::FCW_MODE_SAMPLE:
      begin
        if (ws_rise)
        begin
          out_d = res;
        end
      end
      fcw_pkg::FCW_MODE_WINDOW:
      begin
        if (win_open_now)
        begin
          out_d = res;
        end
        else
        begin
          out_d = ctrl.closed_level;
        end
      end
      fcw_pkg::FCW_MODE_CONT:
      begin
        out_d = filt_bypass ? res : filt_q;
      end
      default:
      begin
        out_d = out_q;
      end
    endcase
    event_d = out_d & ~out_q;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      out_q <= `FCW_RST_OUT;
      event_q <= 1'b0;
    end
    else
    begin
      out_q <= out_d;
      event_q <= event_d;
    end
  end

  // Hardware event path: no software between compare and the PWM fault input
  assign comparator_result = out_q;
  assign compare_event = event_q;

  // Analog front-end controls
  fcw_pkg::fcw_ana_out_s ana_q;
  fcw_pkg::fcw_ana_out_s ana_d;

  always_comb
  begin
    ana_d.plus_sel = ana_cfg.plus_input_select;
    ana_d.minus_sel = ana_cfg.minus_input_select;
    ana_d.plus_connected = fcw_mux_connected(ana_cfg.plus_input_select);
    ana_d.minus_connected = fcw_mux_connected(ana_cfg.minus_input_select);
    ana_d.plus_from_dac = fcw_mux_dac(ana_cfg.plus_input_select);
    ana_d.minus_from_dac = fcw_mux_dac(ana_cfg.minus_input_select);
    ana_d.dac_enable = ana_d.plus_from_dac | ana_d.minus_from_dac;
    ana_d.dac_code = ana_cfg.dac_code;
    // Level numerator over 256: code 0 gives 1/256, code 255 the full reference
    ana_d.dac_level = {1'b0, ana_cfg.dac_code} + 9'h001;
    ana_d.ref_select = ana_cfg.ref_select;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      ana_q.plus_sel <= `FCW_RST_MUX_SEL;
      ana_q.minus_sel <= `FCW_RST_MUX_SEL;
      ana_q.plus_connected <= 1'b1;
      ana_q.minus_connected <= 1'b1;
      ana_q.plus_from_dac <= 1'b0;
      ana_q.minus_from_dac <= 1'b0;
      ana_q.dac_enable <= 1'b0;
      ana_q.dac_code <= `FCW_RST_DAC_CODE;
      ana_q.dac_level <= 9'h001;
      ana_q.ref_select <= 1'b0;
    end
    else
    begin
      ana_q <= ana_d;
    end
  end

  assign ana_out = ana_q;

  // Status
  fcw_pkg::fcw_mode_e mode_q;

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      mode_q <= fcw_pkg::FCW_MODE_CONT;
    end
    else
    begin
      mode_q <= mode;
    end
  end

  assign mode_active = mode_q;
  assign window_is_open = (win_q == fcw_pkg::FCW_WIN_OPEN);

endmodule // fcw_top

`default_nettype wire

// >>> testbench/fcw_top_chk.sv
`timescale 1ns/1ps
`default_nettype none

module fcw_top_chk
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Inputs of the block
  input wire fcw_pkg::fcw_ctrl_s ctrl,
  input wire fcw_pkg::fcw_ana_cfg_s ana_cfg,
  input wire logic cmp_raw,
  input wire logic window_sample_in,
  // Outputs of the block
  input wire logic comparator_result,
  input wire logic compare_event,
  input wire fcw_pkg::fcw_ana_out_s ana_out,
  input wire logic window_is_open,
  input wire fcw_pkg::fcw_mode_e mode_active
);
  logic res;
  logic ws;
  logic smode;
  logic wmode;
  logic cmode;
  assign res = cmp_raw ^ ctrl.output_invert;
  assign ws = window_sample_in ^ ctrl.window_polarity_invert;
  assign smode = ctrl.sample_mode && (ctrl.filter_sample_count == 3'h1);
  assign wmode = !smode && ctrl.window_mode && (ctrl.filter_sample_count == 3'h0);
  assign cmode = !smode && !wmode && (ctrl.filter_sample_count <= 3'h1);

  default clocking chk_cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  // The first cycle after release is left out: its past values come from reset
  AST_SAMPLE_CAPTURE: assert property (
    $past(rst_n) && smode && ws && !$past(ws) |=> comparator_result == $past(res))
    else $error("Sampled result differs from the comparison at the sample edge");
  AST_SAMPLE_HOLD: assert property (
    $past(rst_n) && smode && !(ws && !$past(ws)) |=> $stable(comparator_result))
    else $error("Sampled result changed without a sample edge");
  AST_WIN_PASS: assert property (
    wmode && ws && window_is_open |=> comparator_result == $past(res))
    else $error("Open window does not pass the comparison");
  AST_WIN_CLOSED: assert property (
    wmode && !ws |=> comparator_result == $past(ctrl.closed_level))
    else $error("Closed window does not show the closed level");
  AST_EARLY_CLOSE: assert property (
    wmode && ws && window_is_open && ctrl.window_close_enable &&
    (($rose(res) && ctrl.close_edge_select[0]) || ($fell(res) && ctrl.close_edge_select[1]))
    |=> !window_is_open)
    else $error("Selected output edge did not close the window");
  AST_STAY_CLOSED: assert property (
    $past(rst_n) && $past(wmode) && $past(ws) && wmode && ws && !window_is_open
    |=> !window_is_open && comparator_result == $past(ctrl.closed_level))
    else $error("Early closed window reopened while the source stayed active");
  AST_EVENT: assert property (
    compare_event == (comparator_result && !$past(comparator_result)))
    else $error("Compare event does not mark the rise of the result");
  AST_CONT: assert property (
    cmode |=> comparator_result == $past(res))
    else $error("Continuous result does not follow the comparison");
  AST_ANALOG: assert property (
    1'b1 |=> ana_out.dac_level == {1'b0, $past(ana_cfg.dac_code)} + 9'h001 &&
    ana_out.ref_select == $past(ana_cfg.ref_select) &&
    ana_out.plus_from_dac == ($past(ana_cfg.plus_input_select) == 3'h7))
    else $error("Analog controls do not match the configuration");
  AST_MODE: assert property (
    1'b1 |=> mode_active == ($past(smode) ? fcw_pkg::FCW_MODE_SAMPLE :
    $past(wmode) ? fcw_pkg::FCW_MODE_WINDOW : fcw_pkg::FCW_MODE_CONT))
    else $error("Reported mode does not match the controls");

  COV_SAMPLE: cover property (smode && ws && !$past(ws));
  COV_CLOSE: cover property (wmode && ws && $past(window_is_open) && !window_is_open);
  COV_EVENT: cover property (compare_event);
endmodule // fcw_top_chk

`default_nettype wire

// >>> testbench/fcw_timer_model.sv
`timescale 1ns/1ps
`default_nettype none

module fcw_timer_model
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Pulse request
  input wire logic start,
  input wire logic [7:0] high_len,
  // Window or sample source
  output logic ws
);
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;

  // A new start restarts the pulse, so a slow or a prompt source is one call away
  always_comb
  begin
    cnt_d = cnt_q;
    if (start)
      cnt_d = high_len;
    else if (cnt_q != 8'h00)
      cnt_d = cnt_q - 8'h01;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      cnt_q <= 8'h00;
    else
      cnt_q <= cnt_d;
  end

  assign ws = (cnt_q != 8'h00);
endmodule // fcw_timer_model

`default_nettype wire

// >>> testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  fcw_pkg::fcw_ctrl_s ctrl = '0;
  fcw_pkg::fcw_ana_cfg_s ana_cfg = '0;
  logic cmp_raw = 1'b0;
  logic start = 1'b0;
  logic [7:0] high_len = 8'h00;
  logic window_sample_in;
  logic comparator_result;
  logic compare_event;
  logic window_is_open;
  fcw_pkg::fcw_ana_out_s ana_out;
  fcw_pkg::fcw_mode_e mode_active;
  fcw_pkg::fcw_ana_out_s ana_exp;
  logic [7:0] code;
  logic st;
  int err_total = 0;
  int checks = 0;

  always #50 mclk = ~mclk;

  fcw_top i_dut
  (
    .mclk(mclk), .rst_n(rst_n), .ctrl(ctrl), .ana_cfg(ana_cfg), .cmp_raw(cmp_raw),
    .window_sample_in(window_sample_in), .comparator_result(comparator_result),
    .compare_event(compare_event), .ana_out(ana_out), .window_is_open(window_is_open),
    .mode_active(mode_active)
  );

  fcw_timer_model i_tmr
  (
    .mclk(mclk), .rst_n(rst_n), .start(start), .high_len(high_len), .ws(window_sample_in)
  );

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic drv(input logic v);
    @(posedge mclk);
    cmp_raw <= v;
  endtask

  task automatic win(input logic [7:0] n);
    @(posedge mclk);
    high_len <= n;
    start <= 1'b1;
    @(posedge mclk);
    start <= 1'b0;
  endtask

  task automatic give_verdict;
    if (err_total == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    tick(5);
    chk("mode", mode_active, fcw_pkg::FCW_MODE_CONT);
    @(posedge mclk);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      code = (i == 7) ? 8'hFF : 8'(i * 33);
      @(posedge mclk);
      ana_cfg <= {3'(i), 3'(7 - i), code, i[0]};
      ana_exp = {3'(i), 3'(7 - i), i != 2 && i != 6, i != 5 && i != 1, i == 7, i == 0,
                 i == 7 || i == 0, code, {1'b0, code} + 9'h001, i[0]};
      tick(1);
      chk("analog", ana_out, ana_exp);
    end
    for (int k = 0; k < 4; k++)
    begin
      @(posedge mclk);
      ctrl.output_invert <= k[1];
      cmp_raw <= k[0];
      tick(1);
      chk("cont", comparator_result, k[0] ^ k[1]);
      chk("event", compare_event, k == 1);
    end
    @(posedge mclk);
    ctrl <= '{sample_mode: 1'b1, filter_sample_count: 3'h1, default: '0};
    cmp_raw <= 1'b1;
    tick(2);
    chk("hold", comparator_result, 1'b0);
    chk("mode", mode_active, fcw_pkg::FCW_MODE_SAMPLE);
    win(8'h03);
    tick(1);
    chk("capture", comparator_result, 1'b1);
    drv(1'b0);
    tick(3);
    chk("hold", comparator_result, 1'b1);
    win(8'h03);
    tick(1);
    chk("capture", comparator_result, 1'b0);
    tick(3);
    @(posedge mclk);
    ctrl.window_polarity_invert <= 1'b1;
    cmp_raw <= 1'b1;
    tick(1);
    chk("inverted", comparator_result, 1'b1);
    drv(1'b0);
    win(8'h02);
    tick(2);
    chk("inverted", comparator_result, 1'b1);
    tick(1);
    chk("inverted", comparator_result, 1'b0);
    tick(2);
    @(posedge mclk);
    ctrl <= '{window_mode: 1'b1, default: '0};
    cmp_raw <= 1'b1;
    tick(2);
    chk("mode", mode_active, fcw_pkg::FCW_MODE_WINDOW);
    win(8'h04);
    tick(1);
    chk("opening", comparator_result, 1'b1);
    chk("event", compare_event, 1'b1);
    drv(1'b0);
    tick(1);
    chk("pass", comparator_result, 1'b0);
    @(posedge mclk);
    ctrl.closed_level <= 1'b1;
    tick(1);
    chk("closed", comparator_result, 1'b1);
    @(posedge mclk);
    ctrl <= '{window_mode: 1'b1, window_polarity_invert: 1'b1, default: '0};
    cmp_raw <= 1'b1;
    tick(1);
    chk("polarity", comparator_result, 1'b1);
    win(8'h02);
    tick(1);
    chk("polarity", comparator_result, 1'b0);
    for (int s = 1; s < 4; s++)
    begin
      tick(3);
      st = (s == 2);
      @(posedge mclk);
      ctrl <= '{window_mode: 1'b1, window_close_enable: 1'b1, close_edge_select: 2'(s),
                closed_level: st, default: '0};
      cmp_raw <= st;
      win(8'h08);
      tick(1);
      chk("reopen", window_is_open, 1'b1);
      drv(!st);
      tick(1);
      chk("edge", comparator_result, !st);
      tick(1);
      chk("early", comparator_result, st);
      tick(3);
      chk("stays", window_is_open, 1'b0);
    end
    // Ticks every second cycle: the third differing tick lands six cycles in
    @(posedge mclk);
    ctrl <= '{filter_sample_count: 3'h3, filter_period: 8'h01, default: '0};
    cmp_raw <= 1'b0;
    tick(5);
    chk("filter hold", comparator_result, 1'b1);
    chk("mode", mode_active, fcw_pkg::FCW_MODE_CONT);
    tick(2);
    chk("filter", comparator_result, 1'b0);
    give_verdict();
  end

  // Whole run is about 120 cycles
  initial
  begin
    #200000;
    err_total++;
    give_verdict();
  end
endmodule // testbench

bind fcw_top fcw_top_chk i_chk (.mclk(mclk), .rst_n(rst_n), .ctrl(ctrl), .ana_cfg(ana_cfg),
  .cmp_raw(cmp_raw), .window_sample_in(window_sample_in), .comparator_result(comparator_result),
  .compare_event(compare_event), .ana_out(ana_out), .window_is_open(window_is_open),
  .mode_active(mode_active));

`default_nettype wire
